// [rtl/byte_lane_write_mask.sv]
// Burst-of-two memory write port with per-beat byte-lane masking and APB control
//
// What this block does
// - Lane selects are sampled separately with each of the two beats.
// - x18, both selects low: all eighteen bits of the beat are written.
// - x18, select 0 low only: bits 8..0 written, 17..9 kept.
// - x18, select 1 low only: bits 17..9 written, 8..0 kept.
// - x18, both selects high: nothing written for that beat.
// - x9, one select: low writes bits 8..0, high writes nothing.
// - x36, all four selects low: all thirty-six bits written.
// - x36, only select 0 low: bits 8..0 written, rest kept.
// - x36, only select 1, 2 or 3 low: only that 9-bit lane written.
// - x36, all selects high: location unchanged for that beat.
// - Write data is captured on both beats of the burst.
// - Read data is launched on two beats, four and five cycles after the read starts.
// - Comes out of reset deselected with read data undriven.
// - First beat goes to location 2A ({A,0}), second to 2A+1 ({A,1}).
// - Cycle t starts an access; writes carry data at t and t+1, reads return it at t+4 and t+5.
`timescale 1ns/100ps
module byte_lane_write_mask
  import lane_mask_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 write_port_sel_n,
  input  wire logic                 read_port_sel_n,
  input  wire logic [ADDR_W-1:0]    addr,
  input  wire logic [DATA_W-1:0]    data,
  input  wire logic [NUM_LANES-1:0] byte_lane_mask_n,
  output logic      [DATA_W-1:0]    q,
  output logic                      q_oe,
  output logic                      write_ready,
  input  wire logic [APB_AW-1:0]    paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    pins_t                sync1;
    pins_t                sync2;
    wr_state_t            wr;
    rd_state_t            rd;
    logic [DATA_W-1:0]    data0;
    logic [NUM_LANES-1:0] lane_en0;
    wr_req_t              push_req;
    logic                 push_valid;
    logic [ADDR_W-1:0]    rd_addr;
    logic [DATA_W-1:0]    q;
    logic                 q_oe;
    logic                 write_ready;
    logic                 port_en;
    logic                 hold;
    logic [1:0]           org;
    logic                 overrun;
    logic [31:0]          wr_count;
    logic [ADDR_W:0]      peek_addr;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
  } state_t;

  state_t s;
  state_t next_s;

  logic [1:0]           rst_pipe;
  logic                 rst_n;
  logic                 buf_in_ready;
  logic                 buf_out_valid;
  logic                 buf_out_ready;
  wr_req_t              buf_out;
  logic                 apb_access;
  logic                 peek_now;
  logic                 drain;
  logic [DATA_W-1:0]    mem [0:(2**(ADDR_W+1))-1];
  logic [NUM_LANES-1:0] lanes_present;

  //////////////////////////////////////////////////////////////////////////////
  // Reset release

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  //////////////////////////////////////////////////////////////////////////////
  // Lane decode

  always_comb begin
    case (s.org)
      ORG_X9:  lanes_present = LANES_X9;
      ORG_X18: lanes_present = LANES_X18;
      default: lanes_present = LANES_X36;
    endcase
  end

  // Absent lanes never write, so upper selects are ignored in narrow modes
  function automatic logic [NUM_LANES-1:0] lane_enables(
    input logic [NUM_LANES-1:0] mask_n,
    input logic [NUM_LANES-1:0] present
  );
    lane_enables = ~mask_n & present;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Burst buffer

  two_entry_buffer #(
    .W ($bits(wr_req_t))
  ) u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (s.push_valid),
    .in_ready  (buf_in_ready),
    .in_data   (s.push_req),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out)
  );

  assign apb_access    = psel && penable;
  assign peek_now      = apb_access && !pwrite && (paddr == REG_PEEK_DATA);
  // Stall commits while software peeks so it never sees a half-written word
  assign buf_out_ready = !s.hold && !peek_now;
  assign drain         = buf_out_valid && buf_out_ready;

  //////////////////////////////////////////////////////////////////////////////
  // Array

  // Both words of a burst commit in one cycle; lanes are merged per word
  always_ff @(posedge clk) begin
    if (drain) begin
      for (int i = 0; i < NUM_LANES; i++) begin
        if (buf_out.lane_en0[i]) begin
          mem[{buf_out.addr, 1'b0}][i*LANE_W +: LANE_W] <=
            buf_out.data0[i*LANE_W +: LANE_W];
        end
        if (buf_out.lane_en1[i]) begin
          mem[{buf_out.addr, 1'b1}][i*LANE_W +: LANE_W] <=
            buf_out.data1[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s = s;
    next_s.sync1 = '{write_port_sel_n: write_port_sel_n, read_port_sel_n: read_port_sel_n,
                     addr: addr, data: data, byte_lane_mask_n: byte_lane_mask_n};
    next_s.sync2 = s.sync1;
    next_s.push_valid = 1'b0;
    next_s.write_ready = buf_in_ready;

    // Write port: beat 0 then beat 1, each with its own lane mask
    case (s.wr)
      WR_IDLE: begin
        if (!s.sync2.write_port_sel_n && s.port_en) begin
          next_s.data0    = s.sync2.data;
          next_s.lane_en0 = lane_enables(s.sync2.byte_lane_mask_n, lanes_present);
          next_s.wr       = WR_BEAT1;
        end
      end
      WR_BEAT1: begin
        next_s.push_req.addr     = s.sync2.addr;
        next_s.push_req.data0    = s.data0;
        next_s.push_req.lane_en0 = s.lane_en0;
        next_s.push_req.data1    = s.sync2.data;
        next_s.push_req.lane_en1 = lane_enables(s.sync2.byte_lane_mask_n, lanes_present);
        next_s.push_valid        = 1'b1;
        next_s.wr                = WR_IDLE;
      end
      default: begin
        next_s.wr = WR_IDLE;
      end
    endcase

    // Read port: pin address at t, words on q at t+4 and t+5
    next_s.q_oe = 1'b0;
    case (s.rd)
      RD_IDLE, RD_BEAT1: begin
        if (!s.sync2.read_port_sel_n && s.port_en) begin
          next_s.rd_addr = s.sync2.addr;
          next_s.rd      = RD_BEAT0;
        end else begin
          next_s.rd = RD_IDLE;
        end
      end
      RD_BEAT0: begin
        next_s.rd = RD_BEAT1;
      end
      default: begin
        next_s.rd = RD_IDLE;
      end
    endcase
    if (s.rd == RD_BEAT0) begin
      next_s.q    = mem[{s.rd_addr, 1'b0}];
      next_s.q_oe = 1'b1;
    end else if (s.rd == RD_BEAT1) begin
      next_s.q    = mem[{s.rd_addr, 1'b1}];
      next_s.q_oe = 1'b1;
    end

    if (drain) begin
      next_s.wr_count = s.wr_count + COUNT_STEP;
    end

    // APB: one wait state; reads sampled first cycle, writes land on completion
    next_s.pready  = apb_access && !s.pready;
    next_s.pslverr = 1'b0;
    if (apb_access && !s.pready) begin
      next_s.prdata = WORD_ZERO;
      case (paddr)
        REG_CTRL: begin
          next_s.prdata[CTRL_PORT_EN]             = s.port_en;
          next_s.prdata[CTRL_HOLD]                = s.hold;
          next_s.prdata[CTRL_ORG_HI:CTRL_ORG_LO]  = s.org;
        end
        REG_STATUS: begin
          next_s.prdata[STAT_OVERRUN]   = s.overrun;
          next_s.prdata[STAT_BUF_VALID] = buf_out_valid;
          next_s.prdata[STAT_BUF_FULL]  = !buf_in_ready;
          next_s.prdata[STAT_IN_BURST]  = (s.wr == WR_BEAT1);
        end
        REG_WR_COUNT: begin
          next_s.prdata = s.wr_count;
        end
        REG_PEEK_ADDR: begin
          next_s.prdata[ADDR_W:0] = s.peek_addr;
        end
        REG_PEEK_DATA: begin
          // Bus is one word wide, so only the low 32 bits of a 36-bit word show here
          next_s.prdata = 32'(mem[s.peek_addr]);
        end
        default: begin
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_access && s.pready && pwrite) begin
      case (paddr)
        REG_CTRL: begin
          next_s.port_en = pwdata[CTRL_PORT_EN];
          next_s.hold    = pwdata[CTRL_HOLD];
          next_s.org     = pwdata[CTRL_ORG_HI:CTRL_ORG_LO];
        end
        REG_STATUS: begin
          if (pwdata[STAT_OVERRUN]) begin
            next_s.overrun = 1'b0;
          end
        end
        REG_PEEK_ADDR: begin
          next_s.peek_addr = pwdata[ADDR_W:0];
        end
        default: begin
          next_s.peek_addr = s.peek_addr;
        end
      endcase
    end

    // A burst that finds the buffer full is lost; the flag set beats a clear
    if (s.push_valid && !buf_in_ready) begin
      next_s.overrun = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s             <= '0;
      s.sync1       <= PINS_IDLE;
      s.sync2       <= PINS_IDLE;
      s.wr          <= WR_IDLE;
      s.rd          <= RD_IDLE;
      s.q_oe        <= 1'b0;
      s.port_en     <= CTRL_PORT_EN_RST;
      s.hold        <= CTRL_HOLD_RST;
      s.org         <= CTRL_ORG_RST;
      s.peek_addr   <= PEEK_ADDR_RST;
    end else begin
      s <= next_s;
    end
  end

  assign q           = s.q;
  assign q_oe        = s.q_oe;
  assign write_ready = s.write_ready;
  assign prdata      = s.prdata;
  assign pready      = s.pready;
  assign pslverr     = s.pslverr;

endmodule

// [rtl/lane_mask_pkg.sv]
// Shared constants, types and register map for the byte-lane write mask block
package lane_mask_pkg;

  localparam int LANE_W    = 9;
  localparam int NUM_LANES = 4;
  localparam int DATA_W    = LANE_W * NUM_LANES;
  localparam int ADDR_W    = 8;
  localparam int APB_AW    = 8;

  // Organisation codes held in the control register
  localparam logic [1:0] ORG_X9  = 2'h0;
  localparam logic [1:0] ORG_X18 = 2'h1;
  localparam logic [1:0] ORG_X36 = 2'h2;

  // Lanes that exist in each organisation
  localparam logic [NUM_LANES-1:0] LANES_X9  = 4'h1;
  localparam logic [NUM_LANES-1:0] LANES_X18 = 4'h3;
  localparam logic [NUM_LANES-1:0] LANES_X36 = 4'hf;

  // Register byte addresses
  localparam logic [APB_AW-1:0] REG_CTRL      = 8'h00;
  localparam logic [APB_AW-1:0] REG_STATUS    = 8'h04;
  localparam logic [APB_AW-1:0] REG_WR_COUNT  = 8'h08;
  localparam logic [APB_AW-1:0] REG_PEEK_ADDR = 8'h0c;
  localparam logic [APB_AW-1:0] REG_PEEK_DATA = 8'h10;

  // Control fields
  localparam int CTRL_PORT_EN = 0;
  localparam int CTRL_HOLD    = 1;
  localparam int CTRL_ORG_LO  = 2;
  localparam int CTRL_ORG_HI  = 3;

  // Status fields
  localparam int STAT_OVERRUN   = 0;
  localparam int STAT_BUF_VALID = 1;
  localparam int STAT_BUF_FULL  = 2;
  localparam int STAT_IN_BURST  = 3;

  localparam logic             CTRL_PORT_EN_RST = 1'b1;
  localparam logic             CTRL_HOLD_RST    = 1'b0;
  localparam logic [1:0]       CTRL_ORG_RST     = ORG_X36;
  localparam logic [31:0]      WORD_ZERO        = 32'h0000_0000;
  localparam logic [ADDR_W:0]  PEEK_ADDR_RST    = 9'h000;
  localparam logic [31:0]      COUNT_STEP       = 32'h0000_0001;

  typedef enum logic [1:0] {WR_IDLE, WR_BEAT1} wr_state_t;
  typedef enum logic [1:0] {RD_IDLE, RD_BEAT0, RD_BEAT1} rd_state_t;

  typedef struct packed {
    logic                 write_port_sel_n;
    logic                 read_port_sel_n;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    data;
    logic [NUM_LANES-1:0] byte_lane_mask_n;
  } pins_t;

  // One whole burst: two words, each with its own lane write enables
  typedef struct packed {
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    data0;
    logic [NUM_LANES-1:0] lane_en0;
    logic [DATA_W-1:0]    data1;
    logic [NUM_LANES-1:0] lane_en1;
  } wr_req_t;

  localparam pins_t PINS_IDLE = '{write_port_sel_n: 1'b1, read_port_sel_n: 1'b1,
                                  addr: '0, data: '0, byte_lane_mask_n: '1};

endpackage

// [rtl/two_entry_buffer.sv]
// Two-entry valid/ready buffer for whole write bursts
`timescale 1ns/100ps
module two_entry_buffer #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  typedef struct packed {
    logic [W-1:0] slot0;
    logic [W-1:0] slot1;
    logic [1:0]   count;
  } buf_t;

  buf_t s;
  buf_t next_s;
  logic push;
  logic pop;

  assign in_ready  = (s.count != 2'h2);
  assign out_valid = (s.count != 2'h0);
  assign out_data  = s.slot0;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_s = s;
    if (pop) begin
      next_s.slot0 = s.slot1;
    end
    // Push lands behind whatever stays after a pop in the same cycle
    if (push) begin
      if ((s.count == 2'h0) || ((s.count == 2'h1) && pop)) begin
        next_s.slot0 = in_data;
      end else begin
        next_s.slot1 = in_data;
      end
    end
    next_s.count = s.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

// [test/byte_lane_write_mask_sva.sv]
// Port-level assertions for the byte-lane write mask block
`timescale 1ns/100ps
module byte_lane_write_mask_sva (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        read_port_sel_n,
  input wire logic        q_oe,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  // Read port: pin lag of two sync flops plus two pipeline stages
  property p_oe_reset; $rose(rstn) |-> !q_oe [*3]; endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("q_oe driven after reset");
  property p_oe_start; $rose(q_oe) |-> !$past(read_port_sel_n, 4); endproperty
  a_oe_start: assert property (p_oe_start) else $error("q_oe rose without read");
  property p_oe_two; $rose(q_oe) |=> q_oe; endproperty
  a_oe_two: assert property (p_oe_two) else $error("second word missing");
  property p_oe_end; $fell(q_oe) |-> !$past(read_port_sel_n, 6); endproperty
  a_oe_end: assert property (p_oe_end) else $error("q_oe dropped off time");
  ////////////////////////////////////////////////////////////////////////////////
  // Register bus: one wait state, one-cycle answer
  property p_apb_wait; psel && penable && !pready |=> pready; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready late");
  property p_apb_pulse; pready |=> !pready; endproperty
  a_apb_pulse: assert property (p_apb_pulse) else $error("pready too long");
  property p_apb_access; pready |-> psel && penable; endproperty
  a_apb_access: assert property (p_apb_access) else $error("pready outside access");
  property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("bad error answer");
  property p_prdata_hold; $changed(prdata) |-> pready; endproperty
  a_prdata_hold: assert property (p_prdata_hold) else $error("prdata moved idle");
endmodule

bind byte_lane_write_mask byte_lane_write_mask_sva u_sva (
  .clk(clk), .rstn(rstn), .read_port_sel_n(read_port_sel_n), .q_oe(q_oe), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata));

// [test/ctrl_model.sv]
// Memory controller model driving the burst write and read ports
`timescale 1ns/100ps
module ctrl_model
  import lane_mask_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic [DATA_W-1:0]    q,
  input  wire logic                 q_oe,
  output logic                      write_port_sel_n,
  output logic                      read_port_sel_n,
  output logic      [ADDR_W-1:0]    addr,
  output logic      [DATA_W-1:0]    data,
  output logic      [NUM_LANES-1:0] byte_lane_mask_n
);
  initial begin
    write_port_sel_n = 1'b1;
    read_port_sel_n  = 1'b1;
    addr             = '0;
    data             = '0;
    byte_lane_mask_n = '1;
  end
  task automatic write_burst(input logic [7:0] a, input logic [35:0] d0, input logic [3:0] m0,
                             input logic [35:0] d1, input logic [3:0] m1);
    @(posedge clk);
    write_port_sel_n <= 1'b0;
    data             <= d0;
    byte_lane_mask_n <= m0;
    @(posedge clk);
    write_port_sel_n <= 1'b1;
    addr             <= a;
    data             <= d1;
    byte_lane_mask_n <= m1;
  endtask
  // Idle lines toggle so a stale beat can never pass for a fresh one
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      data             <= ~data;
      addr             <= ~addr;
      byte_lane_mask_n <= ~byte_lane_mask_n;
    end
  endtask
  task automatic read_burst(input logic [7:0] a, output logic [35:0] w0, output logic [35:0] w1);
    @(posedge clk);
    read_port_sel_n <= 1'b0;
    addr            <= a;
    @(posedge clk);
    read_port_sel_n <= 1'b1;
    addr            <= ~a;
    // Waits for the answer as long as it takes; the bench timeout ends a hang
    do @(posedge clk); while (q_oe !== 1'b1);
    w0 = q;
    @(posedge clk);
    w1 = q;
  endtask
endmodule

// [test/test_byte_lane_write_mask.sv]
// Self-checking bench for the byte-lane write mask block
`timescale 1ns/100ps
module test_byte_lane_write_mask
  import lane_mask_pkg::*;
;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, write_ready, q_oe, wsel_n, rsel_n;
  logic [7:0]  paddr, addr, a;
  logic [31:0] pwdata, prdata, rd, seed, nb, fail_count, checks, cyc;
  logic [35:0] data, q, d0, d1, d2, d3, w0, w1, pm;
  logic [3:0]  mask_n, m1;
  logic [1:0]  o;
  logic        er;
  logic [3:0]  corner [6] = '{4'hf, 4'he, 4'hd, 4'hb, 4'h7, 4'h0};

  byte_lane_write_mask u_byte_lane_write_mask (.clk(clk), .rstn(rstn), .write_port_sel_n(wsel_n),
    .read_port_sel_n(rsel_n), .addr(addr), .data(data), .byte_lane_mask_n(mask_n), .q(q),
    .q_oe(q_oe), .write_ready(write_ready), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ctrl_model u_ctrl_model (.clk(clk), .q(q), .q_oe(q_oe), .write_port_sel_n(wsel_n),
    .read_port_sel_n(rsel_n), .addr(addr), .data(data), .byte_lane_mask_n(mask_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    {psel, penable, paddr, pwrite, pwdata} <= {2'b10, ad, w, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Lanes outside the organisation never change; old content elsewhere is kept
  function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw,
                                        input logic [3:0] m, input logic [1:0] org);
    logic [3:0]  pres;
    logic [35:0] r;
    pres = (org == ORG_X9) ? 4'h1 : (org == ORG_X18) ? 4'h3 : 4'hf;
    r = old;
    for (int i = 0; i < 4; i++) if (pres[i] && !m[i]) r[i*9+:9] = nw[i*9+:9];
    return r;
  endfunction
  function automatic logic [35:0] rnd36();
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    return r[35:0];
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    // Free-running and never stopped, so it never needs parking high
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'h1388) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    {seed, nb, fail_count, checks, cyc} = {32'ha311f572, 128'h0};
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk("q_oe", q_oe, 1'b0);
    apb(REG_CTRL, 1'b0, 32'h0, rd, er);
    chk("ctrl", rd, 32'h9);
    apb(REG_STATUS, 1'b0, 32'h0, rd, er);
    chk("status", rd, 32'h0);
    apb(8'h20, 1'b0, 32'h0, rd, er);
    chk("unmapped", er, 1'b1);
    // Code 3 is not a documented organisation and must behave as the widest one
    for (int k = 0; k < 4; k++) begin
      o = k[1:0];
      apb(REG_CTRL, 1'b1, {28'h0, o, 2'h1}, rd, er);
      pm = merge('0, '1, 4'h0, o);
      for (int i = 0; i < 6; i++) begin
        a  = 8'($random(seed));
        d0 = rnd36();
        d1 = rnd36();
        d2 = rnd36();
        d3 = rnd36();
        m1 = 4'($random(seed));
        // Base burst then masked burst back to back, same location
        u_ctrl_model.write_burst(a, d0, 4'h0, d1, 4'h0);
        u_ctrl_model.write_burst(a, d2, corner[i], d3, m1);
        u_ctrl_model.idle(10);
        u_ctrl_model.read_burst(a, w0, w1);
        chk("word0", w0 & pm, merge(d0, d2, corner[i], o) & pm);
        chk("word1", w1 & pm, merge(d1, d3, m1, o) & pm);
        nb = nb + 32'h2;
      end
    end
    apb(REG_WR_COUNT, 1'b0, 32'h0, rd, er);
    chk("count", rd, nb);
    // Held drain: two bursts fill the buffer, the third is refused
    apb(REG_CTRL, 1'b1, 32'hb, rd, er);
    repeat (3) u_ctrl_model.write_burst(8'($random(seed)), rnd36(), 4'h0, rnd36(), 4'h0);
    u_ctrl_model.idle(6);
    chk("ready", write_ready, 1'b0);
    apb(REG_STATUS, 1'b0, 32'h0, rd, er);
    chk("full", rd, 32'h7);
    apb(REG_STATUS, 1'b1, 32'h1, rd, er);
    apb(REG_CTRL, 1'b1, 32'h9, rd, er);
    u_ctrl_model.idle(10);
    apb(REG_STATUS, 1'b0, 32'h0, rd, er);
    chk("drained", rd, 32'h0);
    chk("ready", write_ready, 1'b1);
    apb(REG_WR_COUNT, 1'b0, 32'h0, rd, er);
    chk("count", rd, nb + 32'h2);
    test_done();
  end
endmodule
